/* File: pkg/reset_cause_consts.svh */
// Offsets, bit positions and reset values of the reset cause recorder.
// Assumes inclusion by bare name from the package and bench files.
`ifndef RESET_CAUSE_CONSTS_SVH
`define RESET_CAUSE_CONSTS_SVH

// Register offsets on the plain register port
`define RC_OFF_CAUSE     8'h00
`define RC_OFF_IRQ_STAT  8'h04
`define RC_OFF_IRQ_MASK  8'h08
`define RC_OFF_SEG_LO    8'h0c
`define RC_OFF_SEG_HI    8'h10
`define RC_OFF_SEG_ENTRY 8'h14
`define RC_OFF_CTRL      8'h18
`define RC_OFF_WINIT     8'h1c

// Cause flag bit positions
`define RC_BIT_TRAP  15
`define RC_BIT_IOP   14
`define RC_BIT_CM    9
`define RC_BIT_EXT   7
`define RC_BIT_SWR   6
`define RC_BIT_WATCHDOG_TIMEOUT_FLAG  4
`define RC_BIT_SLEEP 3
`define RC_BIT_IDLE  2
`define RC_BIT_BOR   1
`define RC_BIT_POR   0

// Implemented cause bits; the rest read as zero
`define RC_IMPL_MASK 16'hc2df
// Value after power-on
`define RC_POR_VALUE 16'h0003
// Bits that survive a brown-out
`define RC_BOR_KEEP  16'h0081

// Control bit: protected segment checking enabled
`define RC_CTRL_SEG_EN 0
`define RC_CTRL_RESET  1'h0

`endif

/* File: pkg/reset_cause_pkg.sv */
// Types shared by the reset cause recorder files.
// Assumes reset_cause_consts.svh is on the include path.
package reset_cause_pkg;
    `include "reset_cause_consts.svh"

    // Kind of program counter reload reported by the core
    typedef enum logic [3:0] {
        FLOW_NONE      = 4'h0,
        FLOW_CALL      = 4'h1,
        FLOW_JUMP      = 4'h2,
        FLOW_COMP_JUMP = 4'h3,
        FLOW_RETURN    = 4'h4,
        FLOW_RET_SUB   = 4'h5,
        FLOW_BRANCH    = 4'h6,
        FLOW_INT_VEC   = 4'h7,
        FLOW_TRAP_VEC  = 4'h8
    } flow_kind_t;
endpackage

/* File: pkg/wreg_track_if.sv */
// Link between the recorder top and the working register tracker.
// Assumes both ends share one clock and reset.
interface wreg_track_if #(
    parameter int NUM_W = 16,
    parameter int IDX_W = 4,
    parameter int W_DW  = 16
);
    logic             clear;
    logic             wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [W_DW-1:0]  wr_data;
    logic [IDX_W-1:0] rd_idx;
    logic [W_DW-1:0]  rd_data;
    logic             ptr_en;
    logic [IDX_W-1:0] ptr_idx;
    logic             ptr_uninit;
    logic [NUM_W-1:0] init_vec;

    modport owner (output clear, wr_en, wr_idx, wr_data, rd_idx,
                   ptr_en, ptr_idx,
                   input  rd_data, ptr_uninit, init_vec);
    modport tracker (input  clear, wr_en, wr_idx, wr_data, rd_idx,
                     ptr_en, ptr_idx,
                     output rd_data, ptr_uninit, init_vec);
endinterface

/* File: logic/wreg_init_tracker.sv */
// Working register array with per-register written marks.
// Assumes clear is a one-cycle pulse on any device reset.
module wreg_init_tracker #(
    parameter int NUM_W = 16,
    parameter int IDX_W = 4,
    parameter int W_DW  = 16
) (
    // Clock and reset
    input wire logic     clk,
    input wire logic     rst_b,
    // Owner side
    wreg_track_if.tracker trk
);
    import reset_cause_pkg::*;

    localparam logic [IDX_W-1:0] TOP_IDX = IDX_W'(NUM_W - 1);

    logic [W_DW-1:0]  wreg_q [NUM_W];
    logic [NUM_W-1:0] init_q;
    logic [NUM_W-1:0] top_bit;

    assign top_bit = {1'b1, {(NUM_W-1){1'b0}}};

    // Only the power-on reset clears the top register, so it never counts as unwritten
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_W; i++) begin
                wreg_q[i] <= '0;
            end
            init_q <= '0;
        end else if (trk.clear) begin
            for (int i = 0; i < NUM_W - 1; i++) begin
                wreg_q[i] <= '0; // R2
            end
            init_q <= '0; // R2
        end else if (trk.wr_en) begin
            wreg_q[trk.wr_idx] <= trk.wr_data;
            init_q[trk.wr_idx] <= 1'b1;
        end
    end

    assign trk.rd_data    = wreg_q[trk.rd_idx];
    assign trk.init_vec   = init_q | top_bit;
    assign trk.ptr_uninit = trk.ptr_en && (trk.ptr_idx != TOP_IDX)
                            && !init_q[trk.ptr_idx]; // R1
endmodule // wreg_init_tracker

/* File: logic/reset_cause_recorder.sv */
// Reset cause recorder: sticky cause flags, uninitialised pointer and
// protected segment resets, working register tracking, interrupt.
// Assumes RST_B is the power-on reset and all event inputs are one-cycle
// pulses synchronous to CORE_CLK.
//
// Design decisions made here: the register offsets and the plain strobed port.

//////////////////////////////////////////////////////////////////////////////
// How it works
// R1: Pointer use of an unwritten working register requests a device reset.
// R2: Any reset clears every working register but the top one, which only power-on clears; marks unwritten.
// R3: Flow change into a restricted protected-segment address forces security reset.
// R4: Calls, jumps, computed jumps, returns and branches count as program flow changes.
// R5: Interrupt and trap vector loads count as vector flow changes.
// R6: Trap conflict sets bit 15; only power-on or brown-out clears it.
// R7: Illegal opcode, unwritten pointer or security reset set bit 14.
// R8: Configuration mismatch sets bit 9; only power-on or brown-out clears it.
// R9: Pin reset sets bit 7; only power-on clears it, brown-out keeps it.
// R10: Reset instruction sets bit 6; only power-on or brown-out clears it.
// R11: Watchdog expiry sets bit 4; power-save, watchdog clear, power-on, brown-out clear.
// R12: Sleep power-save sets bit 3; only power-on or brown-out clears it.
// R13: Idle power-save sets bit 2; only power-on or brown-out clears it.
// R14: Power-on sets bits 1 and 0, brown-out sets bit 1; never hardware-cleared.
// R15: Software may write every cause flag to set or clear it.
// R16: Cause register stays readable after every kind of reset.
// R17: Software should clear cause flags after reading them.
// R18: A hardware set beats a software clear in the same cycle.
module reset_cause_recorder #(
    parameter int NUM_W = 16,
    parameter int IDX_W = 4,
    parameter int W_DW  = 16,
    parameter int PC_W  = 24,
    parameter int AW    = 8,
    parameter int DW    = 32
) (
    // Clock and power-on reset
    input  wire logic                    CORE_CLK,
    input  wire logic                    RST_B,
    // Register port
    input  wire logic [AW-1:0]           ADDR,
    input  wire logic [DW-1:0]           WDATA,
    input  wire logic                    WR_STB,
    input  wire logic                    RD_STB,
    output logic      [DW-1:0]           RDATA,
    // Reset and power events from the core
    input  wire logic                    BOR_EVT,
    input  wire logic                    TRAP_CONFLICT,
    input  wire logic                    ILLEGAL_OPCODE,
    input  wire logic                    CFG_MISMATCH,
    input  wire logic                    MASTER_CLEAR_PIN,
    input  wire logic                    RESET_INSTR,
    input  wire logic                    WDT_EXPIRE,
    input  wire logic                    WDT_CLEAR_INSTR,
    input  wire logic                    POWER_SAVE_INSTR_SLEEP,
    input  wire logic                    POWER_SAVE_INSTR_IDLE,
    // Program counter reload
    input  wire logic                    PC_LOAD_EN,
    input  wire reset_cause_pkg::flow_kind_t PC_LOAD_KIND,
    input  wire logic [PC_W-1:0]         PC_TARGET,
    // Working register file
    input  wire logic                    WREG_WR_EN,
    input  wire logic [IDX_W-1:0]        WREG_WR_IDX,
    input  wire logic [W_DW-1:0]         WREG_WR_DATA,
    input  wire logic [IDX_W-1:0]        WREG_RD_IDX,
    output logic      [W_DW-1:0]         WREG_RD_DATA,
    input  wire logic                    PTR_USE_EN,
    input  wire logic [IDX_W-1:0]        PTR_IDX,
    // Results
    output logic                         DEV_RESET_REQ,
    output logic                         IRQ
);
    import reset_cause_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Flow classification

    function automatic logic is_pfc(input flow_kind_t k);
        return k inside {FLOW_CALL, FLOW_JUMP, FLOW_COMP_JUMP, FLOW_RETURN,
                         FLOW_RET_SUB, FLOW_BRANCH};
    endfunction

    function automatic logic is_vfc(input flow_kind_t k);
        return k inside {FLOW_INT_VEC, FLOW_TRAP_VEC};
    endfunction

    function automatic logic [15:0] bit16(input int pos);
        return 16'h0001 << pos;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Registers and tracker link

    logic [15:0]     cause_q, cause_d;
    logic [15:0]     stat_q, stat_d;
    logic [15:0]     mask_q;
    logic [PC_W-1:0] seg_lo_q, seg_hi_q, seg_entry_q;
    logic            ctrl_seg_en_q;
    logic [DW-1:0]   rdata_q;
    logic            dev_reset_q;

    wreg_track_if #(.NUM_W(NUM_W), .IDX_W(IDX_W), .W_DW(W_DW)) trk ();

    wreg_init_tracker #(.NUM_W(NUM_W), .IDX_W(IDX_W), .W_DW(W_DW)) u_trk (
        .clk   (CORE_CLK),
        .rst_b (RST_B),
        .trk   (trk.tracker)
    );

    //////////////////////////////////////////////////////////////////////////
    // Decode

    wire wr_cause = WR_STB && (ADDR == `RC_OFF_CAUSE);
    wire wr_stat  = WR_STB && (ADDR == `RC_OFF_IRQ_STAT);
    wire wr_mask  = WR_STB && (ADDR == `RC_OFF_IRQ_MASK);
    wire wr_lo    = WR_STB && (ADDR == `RC_OFF_SEG_LO);
    wire wr_hi    = WR_STB && (ADDR == `RC_OFF_SEG_HI);
    wire wr_entry = WR_STB && (ADDR == `RC_OFF_SEG_ENTRY);
    wire wr_ctrl  = WR_STB && (ADDR == `RC_OFF_CTRL);

    // Flow changes into the segment other than its entry point are refused
    wire flow_chg   = PC_LOAD_EN
                      && (is_pfc(PC_LOAD_KIND) || is_vfc(PC_LOAD_KIND)); // R4 R5
    wire in_seg     = (PC_TARGET >= seg_lo_q) && (PC_TARGET <= seg_hi_q);
    wire sec_viol   = ctrl_seg_en_q && flow_chg && in_seg
                      && (PC_TARGET != seg_entry_q); // R3
    wire uninit_ptr = trk.ptr_uninit; // R1

    // Any event that resets the device wipes every working register but the top one
    wire reset_evt = BOR_EVT | TRAP_CONFLICT | ILLEGAL_OPCODE | CFG_MISMATCH
                   | MASTER_CLEAR_PIN | RESET_INSTR | WDT_EXPIRE
                   | uninit_ptr | sec_viol;

    assign trk.clear   = reset_evt; // R2
    assign trk.wr_en   = WREG_WR_EN;
    assign trk.wr_idx  = WREG_WR_IDX;
    assign trk.wr_data = WREG_WR_DATA;
    assign trk.rd_idx  = WREG_RD_IDX;
    assign trk.ptr_en  = PTR_USE_EN;
    assign trk.ptr_idx = PTR_IDX;
    assign WREG_RD_DATA = trk.rd_data;

    //////////////////////////////////////////////////////////////////////////
    // Cause flags

    wire [15:0] hw_set =
          (TRAP_CONFLICT ? bit16(`RC_BIT_TRAP) : 16'h0000) // R6
        | ((ILLEGAL_OPCODE | uninit_ptr | sec_viol)
              ? bit16(`RC_BIT_IOP) : 16'h0000) // R7
        | (CFG_MISMATCH ? bit16(`RC_BIT_CM) : 16'h0000) // R8
        | (MASTER_CLEAR_PIN ? bit16(`RC_BIT_EXT) : 16'h0000) // R9
        | (RESET_INSTR ? bit16(`RC_BIT_SWR) : 16'h0000) // R10
        | (WDT_EXPIRE ? bit16(`RC_BIT_WATCHDOG_TIMEOUT_FLAG) : 16'h0000) // R11
        | (POWER_SAVE_INSTR_SLEEP ? bit16(`RC_BIT_SLEEP) : 16'h0000) // R12
        | (POWER_SAVE_INSTR_IDLE ? bit16(`RC_BIT_IDLE) : 16'h0000) // R13
        | (BOR_EVT ? bit16(`RC_BIT_BOR) : 16'h0000); // R14

    wire [15:0] hw_clr =
          (BOR_EVT ? ~`RC_BOR_KEEP : 16'h0000) // R9
        | ((POWER_SAVE_INSTR_SLEEP | POWER_SAVE_INSTR_IDLE | WDT_CLEAR_INSTR)
              ? bit16(`RC_BIT_WATCHDOG_TIMEOUT_FLAG) : 16'h0000); // R11

    wire [15:0] cause_base = wr_cause ? WDATA[15:0] : cause_q; // R15

    // Set applied last so it wins over any clear
    assign cause_d = ((cause_base & ~hw_clr) | hw_set)
                     & `RC_IMPL_MASK; // R18

    // Only the power-on reset touches this register asynchronously
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cause_q <= `RC_POR_VALUE; // R14
        end else begin
            cause_q <= cause_d; // R16
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask, same layout as the cause register

    wire [15:0] stat_w1c = wr_stat ? WDATA[15:0] : 16'h0000;
    assign stat_d = ((stat_q & ~stat_w1c) | hw_set) & `RC_IMPL_MASK;

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            stat_q <= 16'h0000;
            mask_q <= 16'h0000;
        end else begin
            stat_q <= stat_d;
            if (wr_mask) begin
                mask_q <= WDATA[15:0] & `RC_IMPL_MASK;
            end
        end
    end

    assign IRQ = |(stat_q & mask_q);

    //////////////////////////////////////////////////////////////////////////
    // Protected segment setup

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            seg_lo_q      <= '0;
            seg_hi_q      <= '0;
            seg_entry_q   <= '0;
            ctrl_seg_en_q <= `RC_CTRL_RESET;
        end else begin
            if (wr_lo)    seg_lo_q      <= WDATA[PC_W-1:0];
            if (wr_hi)    seg_hi_q      <= WDATA[PC_W-1:0];
            if (wr_entry) seg_entry_q   <= WDATA[PC_W-1:0];
            if (wr_ctrl)  ctrl_seg_en_q <= WDATA[`RC_CTRL_SEG_EN];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Reset request and read port

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            dev_reset_q <= 1'b0;
        end else begin
            dev_reset_q <= uninit_ptr | sec_viol; // R1 R3
        end
    end

    assign DEV_RESET_REQ = dev_reset_q;

    logic [DW-1:0] rd_sel;
    always_comb begin
        rd_sel = '0;
        unique case (ADDR)
            `RC_OFF_CAUSE:     rd_sel = DW'(cause_q); // R16
            `RC_OFF_IRQ_STAT:  rd_sel = DW'(stat_q);
            `RC_OFF_IRQ_MASK:  rd_sel = DW'(mask_q);
            `RC_OFF_SEG_LO:    rd_sel = DW'(seg_lo_q);
            `RC_OFF_SEG_HI:    rd_sel = DW'(seg_hi_q);
            `RC_OFF_SEG_ENTRY: rd_sel = DW'(seg_entry_q);
            `RC_OFF_CTRL:      rd_sel = DW'(ctrl_seg_en_q);
            `RC_OFF_WINIT:     rd_sel = DW'(trk.init_vec);
            default:           rd_sel = '0;
        endcase
    end

    // Data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= RD_STB ? rd_sel : '0;
        end
    end

    assign RDATA = rdata_q;

    //////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    chk_uninit_reset: assert property ( // R1
        PTR_USE_EN && !trk.init_vec[PTR_IDX]
        |=> DEV_RESET_REQ && cause_q[`RC_BIT_IOP])
        else $error("unwritten pointer use did not reset");

    chk_wreg_clear: assert property ( // R2
        reset_evt |=> trk.init_vec == {1'b1, {(NUM_W-1){1'b0}}})
        else $error("working registers not marked unwritten");

    chk_sec_reset: assert property ( // R3
        ctrl_seg_en_q && PC_LOAD_EN && is_pfc(PC_LOAD_KIND) && in_seg
        && PC_TARGET != seg_entry_q |=> DEV_RESET_REQ)
        else $error("restricted flow change not reset");

    chk_pfc_kind: assert property ( // R4
        PC_LOAD_EN && PC_LOAD_KIND inside {FLOW_CALL, FLOW_RETURN,
        FLOW_BRANCH} |-> flow_chg)
        else $error("program flow change not classified");

    chk_vfc_kind: assert property ( // R5
        PC_LOAD_EN && PC_LOAD_KIND == FLOW_TRAP_VEC |-> flow_chg)
        else $error("vector flow change not classified");

    chk_trap_flag: assert property ( // R6
        TRAP_CONFLICT |=> cause_q[`RC_BIT_TRAP])
        else $error("trap conflict flag not set");

    chk_iop_flag: assert property ( // R7
        ILLEGAL_OPCODE |=> cause_q[`RC_BIT_IOP])
        else $error("illegal operation flag not set");

    chk_cm_flag: assert property ( // R8
        CFG_MISMATCH |=> cause_q[`RC_BIT_CM])
        else $error("mismatch flag not set");

    chk_ext_keep: assert property ( // R9
        BOR_EVT && !wr_cause && !MASTER_CLEAR_PIN
        |=> cause_q[`RC_BIT_EXT] == $past(cause_q[`RC_BIT_EXT]))
        else $error("brown-out changed pin reset flag");

    chk_swr_flag: assert property ( // R10
        RESET_INSTR ##1 !BOR_EVT && !wr_cause
        |=> cause_q[`RC_BIT_SWR] [*2])
        else $error("reset instruction flag not sticky");

    chk_watchdog_timeout_flag_clear: assert property ( // R11
        WDT_CLEAR_INSTR && !WDT_EXPIRE |=> !cause_q[`RC_BIT_WATCHDOG_TIMEOUT_FLAG])
        else $error("watchdog flag not cleared");

    chk_sleep_idle: assert property ( // R12 R13
        POWER_SAVE_INSTR_SLEEP || POWER_SAVE_INSTR_IDLE
        |=> cause_q[`RC_BIT_SLEEP] || cause_q[`RC_BIT_IDLE])
        else $error("power-save flag not set");

    chk_bor_flag: assert property ( // R14
        BOR_EVT |=> cause_q[`RC_BIT_BOR]
        && cause_q[`RC_BIT_POR] == $past(cause_q[`RC_BIT_POR]))
        else $error("brown-out flags wrong");

    chk_sw_write: assert property ( // R15
        wr_cause && hw_set == 16'h0000 && hw_clr == 16'h0000
        |=> cause_q == ($past(WDATA[15:0]) & `RC_IMPL_MASK))
        else $error("software write not taken");

    chk_cause_read: assert property ( // R16
        RD_STB && ADDR == `RC_OFF_CAUSE
        |=> RDATA == DW'($past(cause_q)))
        else $error("cause read wrong");

    chk_set_wins: assert property ( // R18
        TRAP_CONFLICT && wr_cause && !WDATA[`RC_BIT_TRAP]
        |=> cause_q[`RC_BIT_TRAP])
        else $error("software clear beat hardware set");
endmodule // reset_cause_recorder

/* File: verif/tb.sv */
// Self-checking bench for the reset cause recorder top module.
// Assumes the package and header on the include path; drives every port.
`include "reset_cause_consts.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import reset_cause_pkg::*;

    typedef struct {
        logic [1:0]  k;
        logic        sel;
        logic [31:0] exp;
        string       nm;
    } note_t;

    logic              CORE_CLK;
    logic              RST_B;
    logic [7:0]        ADDR;
    logic [31:0]       WDATA;
    logic              WR_STB;
    logic              RD_STB;
    logic [31:0]       RDATA;
    logic [9:0]        evt;
    logic              PC_LOAD_EN;
    flow_kind_t        PC_LOAD_KIND;
    logic [23:0]       PC_TARGET;
    logic              WREG_WR_EN;
    logic [3:0]        WREG_WR_IDX;
    logic [15:0]       WREG_WR_DATA;
    logic [3:0]        WREG_RD_IDX;
    logic [15:0]       WREG_RD_DATA;
    logic              PTR_USE_EN;
    logic [3:0]        PTR_IDX;
    logic              DEV_RESET_REQ;
    logic              IRQ;
    logic              rd_vld;
    logic              req_vld;
    logic              prb_vld;
    logic              prb_sel;
    logic [31:0]       prb_val;
    note_t             nq[$];
    int                num_errors;
    int                n_compared;
    int                seed;
    int                bitpos[8];
    logic [31:0]       rv;

    reset_cause_recorder i_dut (
        .CORE_CLK(CORE_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
        .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
        .BOR_EVT(evt[9]), .TRAP_CONFLICT(evt[0]), .ILLEGAL_OPCODE(evt[1]),
        .CFG_MISMATCH(evt[2]), .MASTER_CLEAR_PIN(evt[3]),
        .RESET_INSTR(evt[4]), .WDT_EXPIRE(evt[5]),
        .WDT_CLEAR_INSTR(evt[8]), .POWER_SAVE_INSTR_SLEEP(evt[6]),
        .POWER_SAVE_INSTR_IDLE(evt[7]), .PC_LOAD_EN(PC_LOAD_EN),
        .PC_LOAD_KIND(PC_LOAD_KIND), .PC_TARGET(PC_TARGET),
        .WREG_WR_EN(WREG_WR_EN), .WREG_WR_IDX(WREG_WR_IDX),
        .WREG_WR_DATA(WREG_WR_DATA), .WREG_RD_IDX(WREG_RD_IDX),
        .WREG_RD_DATA(WREG_RD_DATA), .PTR_USE_EN(PTR_USE_EN),
        .PTR_IDX(PTR_IDX), .DEV_RESET_REQ(DEV_RESET_REQ), .IRQ(IRQ)
    );

    initial begin
        CORE_CLK = 1'b0;
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end

    //////////////////////////////////////////////////////////////////////
    // Result watcher: results are settled by the falling edge
    assign prb_val = prb_sel ? {16'h0000, WREG_RD_DATA} : {31'h0, IRQ};

    always @(posedge CORE_CLK) begin
        rd_vld  <= RD_STB;
        req_vld <= PC_LOAD_EN | PTR_USE_EN;
    end

    task automatic take(input logic [1:0] k, input logic [31:0] v);
        note_t n;
        if (nq.size() == 0 || nq[0].k != k) begin
            num_errors++;
            $display("mismatch unexpected result kind %0d seen %h", k, v);
        end else begin
            n = nq.pop_front();
            n_compared++;
            if (v !== n.exp) begin
                num_errors++;
                $display("mismatch %s expected %h seen %h", n.nm, n.exp, v);
            end
        end
    endtask

    always @(negedge CORE_CLK) begin
        if (rd_vld === 1'b1) take(2'd0, RDATA);
        if (req_vld === 1'b1) take(2'd1, {31'h0, DEV_RESET_REQ});
        if (prb_vld === 1'b1) take(2'd2, prb_val);
    end

    //////////////////////////////////////////////////////////////////////
    // Drivers; each lets one edge pass with strobes low afterwards
    task automatic cyc(input logic w, input logic r, input logic [7:0] a,
                       input logic [31:0] d, input logic [9:0] e);
        @(posedge CORE_CLK);
        WR_STB <= w;
        RD_STB <= r;
        ADDR   <= a;
        WDATA  <= d;
        evt    <= e;
        @(posedge CORE_CLK);
        WR_STB <= 1'b0;
        RD_STB <= 1'b0;
        evt    <= 10'h000;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cyc(1'b1, 1'b0, a, d, 10'h000);
    endtask

    task automatic ev(input logic [9:0] e);
        cyc(1'b0, 1'b0, 8'h00, 32'h0, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input string nm);
        nq.push_back('{2'd0, 1'b0, x, nm});
        cyc(1'b0, 1'b1, a, 32'h0, 10'h000);
    endtask

    task automatic core(input logic pe, input flow_kind_t fk,
                        input logic [23:0] tg, input logic ue,
                        input logic [3:0] pi, input logic x);
        nq.push_back('{2'd1, 1'b0, {31'h0, x}, "reset request"});
        @(posedge CORE_CLK);
        PC_LOAD_EN   <= pe;
        PC_LOAD_KIND <= fk;
        PC_TARGET    <= tg;
        PTR_USE_EN   <= ue;
        PTR_IDX      <= pi;
        @(posedge CORE_CLK);
        PC_LOAD_EN <= 1'b0;
        PTR_USE_EN <= 1'b0;
    endtask

    task automatic wwr(input logic [3:0] i, input logic [15:0] d);
        @(posedge CORE_CLK);
        WREG_WR_EN   <= 1'b1;
        WREG_WR_IDX  <= i;
        WREG_WR_DATA <= d;
        @(posedge CORE_CLK);
        WREG_WR_EN <= 1'b0;
    endtask

    task automatic prb(input logic s, input logic [3:0] i,
                       input logic [31:0] x, input string nm);
        nq.push_back('{2'd2, s, x, nm});
        @(posedge CORE_CLK);
        prb_vld     <= 1'b1;
        prb_sel     <= s;
        WREG_RD_IDX <= i;
        @(posedge CORE_CLK);
        prb_vld <= 1'b0;
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge CORE_CLK);
        num_errors++;
        $display("mismatch run limit expected end seen hang");
        stop_test();
    end

    //////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        RST_B = 1'b0; ADDR = 8'h00; WDATA = 32'h0; WR_STB = 1'b0;
        RD_STB = 1'b0; evt = 10'h000; PC_LOAD_EN = 1'b0;
        PC_LOAD_KIND = FLOW_NONE; PC_TARGET = 24'h0; WREG_WR_EN = 1'b0;
        WREG_WR_IDX = 4'h0; WREG_WR_DATA = 16'h0; WREG_RD_IDX = 4'h0;
        PTR_USE_EN = 1'b0; PTR_IDX = 4'h0; prb_vld = 1'b0; prb_sel = 1'b0;
        num_errors = 0; n_compared = 0; seed = 26550;
        bitpos = '{`RC_BIT_TRAP, `RC_BIT_IOP, `RC_BIT_CM, `RC_BIT_EXT,
                   `RC_BIT_SWR, `RC_BIT_WATCHDOG_TIMEOUT_FLAG, `RC_BIT_SLEEP, `RC_BIT_IDLE};
        repeat (6) @(posedge CORE_CLK);
        RST_B <= 1'b1;

        rd(`RC_OFF_CAUSE, 32'h0003, "cause after power-on");
        rd(`RC_OFF_WINIT, 32'h8000, "written marks");
        rd(`RC_OFF_IRQ_MASK, 32'h0, "mask after reset");
        rd(8'h20, 32'h0, "unmapped read");
        $display("test defaults done");

        for (int i = 0; i < 6; i++) begin
            rv = $random(seed);
            wr(`RC_OFF_CAUSE, rv);
            wr(8'h24, 32'hffffffff);
            rd(`RC_OFF_CAUSE, rv & 32'h0000c2df, "cause write");
        end
        $display("test software write done");

        for (int i = 0; i < 8; i++) begin
            wr(`RC_OFF_CAUSE, 32'h0);
            ev(10'h001 << i);
            rd(`RC_OFF_CAUSE, 32'h1 << bitpos[i], "event flag");
        end
        $display("test event flags done");

        wr(`RC_OFF_CAUSE, 32'h0);
        ev(10'h020);
        ev(10'h100);
        rd(`RC_OFF_CAUSE, 32'h0000, "watchdog clear");
        ev(10'h020);
        ev(10'h040);
        rd(`RC_OFF_CAUSE, 32'h0008, "sleep clears timeout");
        ev(10'h020);
        ev(10'h080);
        rd(`RC_OFF_CAUSE, 32'h000c, "idle clears timeout");
        $display("test power save done");

        wr(`RC_OFF_CAUSE, 32'hffff);
        ev(10'h200);
        rd(`RC_OFF_CAUSE, 32'h0083, "brown-out");
        cyc(1'b1, 1'b0, `RC_OFF_CAUSE, 32'h0, 10'h001);
        rd(`RC_OFF_CAUSE, 32'h8000, "set beats clear");
        $display("test brown-out and precedence done");

        wr(`RC_OFF_IRQ_STAT, 32'hffff);
        wr(`RC_OFF_IRQ_MASK, 32'h0);
        ev(10'h001);
        rd(`RC_OFF_IRQ_STAT, 32'h8000, "status set");
        prb(1'b0, 4'h0, 32'h0, "irq masked");
        wr(`RC_OFF_IRQ_MASK, 32'h8000);
        prb(1'b0, 4'h0, 32'h1, "irq unmasked");
        wr(`RC_OFF_IRQ_STAT, 32'h8000);
        prb(1'b0, 4'h0, 32'h0, "irq cleared");
        rd(`RC_OFF_IRQ_STAT, 32'h0, "status cleared");
        $display("test interrupt done");

        wr(`RC_OFF_CAUSE, 32'h0);
        rv = $random(seed);
        wwr(4'h3, rv[15:0]);
        wwr(4'hf, 16'h5a5a);
        prb(1'b1, 4'h3, {16'h0, rv[15:0]}, "w3 data");
        rd(`RC_OFF_WINIT, 32'h8008, "marks after write");
        core(1'b0, FLOW_NONE, 24'h0, 1'b1, 4'h3, 1'b0);
        core(1'b0, FLOW_NONE, 24'h0, 1'b1, 4'hf, 1'b0);
        core(1'b0, FLOW_NONE, 24'h0, 1'b1, 4'h5, 1'b1);
        rd(`RC_OFF_CAUSE, 32'h4000, "unwritten pointer");
        prb(1'b1, 4'h3, 32'h0, "w3 cleared");
        prb(1'b1, 4'hf, 32'h5a5a, "top register kept");
        rd(`RC_OFF_WINIT, 32'h8000, "marks after reset");
        core(1'b0, FLOW_NONE, 24'h0, 1'b1, 4'h3, 1'b1);
        $display("test working registers done");

        wr(`RC_OFF_CAUSE, 32'h0);
        wr(`RC_OFF_SEG_LO, 32'h100);
        wr(`RC_OFF_SEG_HI, 32'h1ff);
        wr(`RC_OFF_SEG_ENTRY, 32'h140);
        core(1'b1, FLOW_CALL, 24'h180, 1'b0, 4'h0, 1'b0);
        wr(`RC_OFF_CTRL, 32'h1);
        for (int k = 1; k < 9; k++)
            core(1'b1, flow_kind_t'(k), 24'h180, 1'b0, 4'h0, 1'b1);
        core(1'b1, FLOW_NONE, 24'h180, 1'b0, 4'h0, 1'b0);
        core(1'b1, FLOW_JUMP, 24'h140, 1'b0, 4'h0, 1'b0);
        core(1'b1, FLOW_JUMP, 24'h1ff, 1'b0, 4'h0, 1'b1);
        core(1'b1, FLOW_RETURN, 24'h100, 1'b0, 4'h0, 1'b1);
        core(1'b1, FLOW_JUMP, 24'h200, 1'b0, 4'h0, 1'b0);
        core(1'b1, FLOW_TRAP_VEC, 24'h0ff, 1'b0, 4'h0, 1'b0);
        rd(`RC_OFF_CAUSE, 32'h4000, "security flag");
        $display("test security done");

        ev(10'h008);
        @(posedge CORE_CLK);
        RST_B <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        RST_B <= 1'b1;
        rd(`RC_OFF_CAUSE, 32'h0003, "cause after second reset");
        rd(`RC_OFF_CTRL, 32'h0, "control after reset");
        $display("test second reset done");

        for (int i = 0; i < 20 && nq.size() > 0; i++) @(posedge CORE_CLK);
        if (nq.size() > 0) begin
            num_errors++;
            $display("mismatch pending results expected 0 seen %0d",
                     nq.size());
        end
        stop_test();
    end
endmodule // tb
